// ### core/srm_defs.svh
// reset values and fixed widths of the sram-style bus master
// assumes: included by bare name from any file that needs them
`ifndef SRM_DEFS_SVH
`define SRM_DEFS_SVH

// ==========================================================
// widths
`define SRM_ADDR_W 30
`define SRM_LANES 4
`define SRM_DATA_W 32

// ==========================================================
// reset values
`define SRM_ADDR_RST 30'h00000000
`define SRM_LANE_RST 4'h0
`define SRM_DATA_RST 32'h00000000

`endif

// ### core/srm_pkg.sv
// types shared by the sram-style bus master files
// assumes: srm_defs.svh is on the include path
package srm_pkg;

  // ==========================================================
  // transaction kinds, one strobe each
  typedef enum logic [1:0] {
    SRM_K_READ = 2'h0,
    SRM_K_WRITE = 2'h1,
    SRM_K_SYNC = 2'h2
  } srm_kind_t;

  // ==========================================================
  // data side states (one-hot)
  typedef enum logic [2:0] {
    SRM_D_IDLE = 3'h1,
    SRM_D_BUSY = 3'h2,
    SRM_D_REDIR = 3'h4
  } srm_dstate_t;

  // instruction side states (one-hot)
  typedef enum logic [1:0] {
    SRM_I_IDLE = 2'h1,
    SRM_I_BUSY = 2'h2
  } srm_istate_t;

endpackage : srm_pkg

// ### core/srm_lane_capture.sv
// per-byte-lane read data capture registers
// assumes: lane enables and data come from logic on the same clock
`include "srm_defs.svh"

module srm_lane_capture #(
  parameter int LANES = `SRM_LANES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic capture_en,
  input wire logic [LANES-1:0] lane_en,
  input wire logic [8*LANES-1:0] bus,
  output logic [8*LANES-1:0] word
);

  logic [8*LANES-1:0] word_r;
  // a net, so each lane slice below has exactly one driver
  wire [8*LANES-1:0] word_nxt;

  // ==========================================================
  // lane update: unenabled lanes keep old bytes, no check vs request
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      logic [7:0] byte_nxt;
      always_comb begin
        if (capture_en && lane_en[g]) begin
          byte_nxt = bus[8*g +: 8];
        end else begin
          byte_nxt = word_r[8*g +: 8];
        end
      end
      assign word_nxt[8*g +: 8] = byte_nxt;
    end
  endgenerate

  // registers only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_r <= '0;
    end else begin
      word_r <= word_nxt;
    end
  end

  assign word = word_r;

endmodule : srm_lane_capture

// ### core/srm_master.sv
// master end of a synchronous sram-style memory interface, data and
// instruction sides, with data-to-instruction redirection
// assumes: agent runs on clock; core-side requests are same-clock logic
`include "srm_defs.svh"

module srm_master (
  input wire logic clock,
  input wire logic rst_n,
  // data side core request
  input wire logic data_req,
  input wire srm_pkg::srm_kind_t data_req_kind,
  input wire logic [`SRM_ADDR_W-1:0] data_req_addr,
  input wire logic [`SRM_LANES-1:0] data_req_lanes,
  input wire logic [`SRM_DATA_W-1:0] data_req_wdata,
  output logic data_req_ready,
  // data side pins
  output logic data_rd_strobe,
  output logic data_wr_strobe,
  output logic data_sync_strobe,
  output logic [`SRM_ADDR_W-1:0] data_word_addr,
  output logic [`SRM_LANES-1:0] data_out_lane_en,
  output logic [`SRM_DATA_W-1:0] data_wr_bus,
  input wire logic data_wait,
  input wire logic [`SRM_DATA_W-1:0] data_rd_bus,
  input wire logic [`SRM_LANES-1:0] data_in_lane_en,
  input wire logic data_fault,
  input wire logic data_redirect,
  input wire logic data_abort_ack,
  input wire logic data_unlock_ack,
  // data side results
  output logic data_done,
  output logic [`SRM_DATA_W-1:0] data_rd_word,
  output logic data_done_fault,
  output logic data_done_redir,
  output logic data_done_abort_ack,
  output logic data_done_unlock_ack,
  // instruction side core request (fetch reads)
  input wire logic instr_req,
  input wire logic [`SRM_ADDR_W-1:0] instr_req_addr,
  input wire logic [`SRM_LANES-1:0] instr_req_lanes,
  output logic instr_req_ready,
  // instruction side pins
  output logic instr_rd_strobe,
  output logic instr_wr_strobe,
  output logic instr_sync_strobe,
  output logic [`SRM_ADDR_W-1:0] instr_word_addr,
  output logic [`SRM_LANES-1:0] instr_out_lane_en,
  input wire logic instr_wait,
  input wire logic [`SRM_DATA_W-1:0] instr_rd_bus,
  input wire logic [`SRM_LANES-1:0] instr_in_lane_en,
  input wire logic instr_fault,
  // instruction side results
  output logic instr_done,
  output logic [`SRM_DATA_W-1:0] instr_rd_word,
  output logic instr_done_fault
);

  // ==========================================================
  // state
  logic run_r;
  srm_pkg::srm_dstate_t dst_r, dst_nxt;
  srm_pkg::srm_kind_t dkind_r, dkind_nxt;
  logic [`SRM_ADDR_W-1:0] daddr_r, daddr_nxt;
  logic [`SRM_LANES-1:0] dlanes_r, dlanes_nxt;
  logic [`SRM_DATA_W-1:0] dwdata_r, dwdata_nxt;
  srm_pkg::srm_istate_t ist_r, ist_nxt;
  srm_pkg::srm_kind_t ikind_r, ikind_nxt;
  logic [`SRM_ADDR_W-1:0] iaddr_r, iaddr_nxt;
  logic [`SRM_LANES-1:0] ilanes_r, ilanes_nxt;
  logic iredir_r, iredir_nxt;
  logic ddone_r, ddone_nxt, dfault_r, dfault_nxt, dredir_r, dredir_nxt;
  logic dabort_r, dabort_nxt, dunlock_r, dunlock_nxt;
  logic idone_r, idone_nxt, ifault_r, ifault_nxt;

  logic d_busy, d_cmpl, d_free, d_launch, d_show;
  logic i_busy, i_cmpl, i_free, redir_launch, fetch_launch, i_launch, i_show;
  logic redir_busy, redir_done;
  srm_pkg::srm_kind_t d_kind, i_kind;

  // ==========================================================
  // data side handshake
  always_comb begin
    d_busy = (dst_r == srm_pkg::SRM_D_BUSY);
    d_cmpl = d_busy && !data_wait;
    // stalled blocks launch, redirect blocks too
    d_free = (dst_r == srm_pkg::SRM_D_IDLE) || (d_cmpl && !data_redirect);
    // launch in completing cycle; run_r gates it
    d_launch = run_r && data_req && d_free;
    d_show = d_launch || (d_busy && data_wait);
    d_kind = d_launch ? data_req_kind : dkind_r;
  end

  assign data_rd_strobe = d_show && (d_kind == srm_pkg::SRM_K_READ);
  assign data_wr_strobe = d_show && (d_kind == srm_pkg::SRM_K_WRITE);
  assign data_sync_strobe = d_show && (d_kind == srm_pkg::SRM_K_SYNC);
  assign data_word_addr = d_launch ? data_req_addr : daddr_r;
  // lanes passed through as the core encodes them
  assign data_out_lane_en = d_launch ? data_req_lanes : dlanes_r;
  // write data stays on the bus through a redirect, no instr data bus
  assign data_wr_bus = d_launch ? data_req_wdata : dwdata_r;
  assign data_req_ready = run_r && d_free;

  // ==========================================================
  // instruction side handshake; redirected accesses outrank fetches
  always_comb begin
    i_busy = (ist_r == srm_pkg::SRM_I_BUSY);
    i_cmpl = i_busy && !instr_wait;
    i_free = (ist_r == srm_pkg::SRM_I_IDLE) || i_cmpl;
    redir_busy = i_busy && iredir_r;
    redir_done = redir_busy && !instr_wait;
    redir_launch = run_r && (dst_r == srm_pkg::SRM_D_REDIR) && !redir_busy && i_free;
    fetch_launch = run_r && instr_req && i_free && !redir_launch;
    i_launch = redir_launch || fetch_launch;
    i_show = i_launch || (i_busy && instr_wait);
    if (redir_launch) begin
      i_kind = dkind_r;
    end else if (fetch_launch) begin
      i_kind = srm_pkg::SRM_K_READ;
    end else begin
      i_kind = ikind_r;
    end
  end

  assign instr_rd_strobe = i_show && (i_kind == srm_pkg::SRM_K_READ);
  assign instr_wr_strobe = i_show && (i_kind == srm_pkg::SRM_K_WRITE);
  assign instr_sync_strobe = i_show && (i_kind == srm_pkg::SRM_K_SYNC);
  assign instr_word_addr = redir_launch ? daddr_r : (fetch_launch ? instr_req_addr : iaddr_r);
  assign instr_out_lane_en = redir_launch ? dlanes_r :
                             (fetch_launch ? instr_req_lanes : ilanes_r);
  assign instr_req_ready = run_r && i_free && !redir_launch;

  // ==========================================================
  // next state for both sides
  always_comb begin
    dkind_nxt = d_launch ? data_req_kind : dkind_r;
    daddr_nxt = data_word_addr;
    dlanes_nxt = data_out_lane_en;
    dwdata_nxt = data_wr_bus;
    case (dst_r)
      srm_pkg::SRM_D_IDLE: begin
        dst_nxt = d_launch ? srm_pkg::SRM_D_BUSY : srm_pkg::SRM_D_IDLE;
      end
      srm_pkg::SRM_D_BUSY: begin
        if (data_wait) begin
          dst_nxt = srm_pkg::SRM_D_BUSY;
        end else if (data_redirect) begin
          dst_nxt = srm_pkg::SRM_D_REDIR;
        end else if (d_launch) begin
          dst_nxt = srm_pkg::SRM_D_BUSY;
        end else begin
          dst_nxt = srm_pkg::SRM_D_IDLE;
        end
      end
      srm_pkg::SRM_D_REDIR: begin
        dst_nxt = redir_done ? srm_pkg::SRM_D_IDLE : srm_pkg::SRM_D_REDIR;
      end
      default: begin
        dst_nxt = srm_pkg::SRM_D_IDLE;
      end
    endcase
    ist_nxt = (i_launch || (i_busy && instr_wait)) ? srm_pkg::SRM_I_BUSY : srm_pkg::SRM_I_IDLE;
    ikind_nxt = i_kind;
    iaddr_nxt = instr_word_addr;
    ilanes_nxt = instr_out_lane_en;
    iredir_nxt = i_launch ? redir_launch : iredir_r;
  end

  // ==========================================================
  // completion results; status ignored while waiting
  always_comb begin
    ddone_nxt = (d_cmpl && !data_redirect) || redir_done;
    // status pulses only beside done; a redirected leg reports when it ends
    dfault_nxt = (d_cmpl && !data_redirect && data_fault) || (redir_done && instr_fault);
    dredir_nxt = redir_done;
    dabort_nxt = d_cmpl && !data_redirect && data_abort_ack;
    dunlock_nxt = d_cmpl && !data_redirect && data_unlock_ack;
    idone_nxt = i_cmpl && !iredir_r;
    ifault_nxt = i_cmpl && !iredir_r && instr_fault;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
      dst_r <= srm_pkg::SRM_D_IDLE;
      dkind_r <= srm_pkg::SRM_K_READ;
      daddr_r <= `SRM_ADDR_RST;
      dlanes_r <= `SRM_LANE_RST;
      dwdata_r <= `SRM_DATA_RST;
      ist_r <= srm_pkg::SRM_I_IDLE;
      ikind_r <= srm_pkg::SRM_K_READ;
      iaddr_r <= `SRM_ADDR_RST;
      ilanes_r <= `SRM_LANE_RST;
      iredir_r <= 1'b0;
      ddone_r <= 1'b0;
      dfault_r <= 1'b0;
      dredir_r <= 1'b0;
      dabort_r <= 1'b0;
      dunlock_r <= 1'b0;
      idone_r <= 1'b0;
      ifault_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
      dst_r <= dst_nxt;
      dkind_r <= dkind_nxt;
      daddr_r <= daddr_nxt;
      dlanes_r <= dlanes_nxt;
      dwdata_r <= dwdata_nxt;
      ist_r <= ist_nxt;
      ikind_r <= ikind_nxt;
      iaddr_r <= iaddr_nxt;
      ilanes_r <= ilanes_nxt;
      iredir_r <= iredir_nxt;
      ddone_r <= ddone_nxt;
      dfault_r <= dfault_nxt;
      dredir_r <= dredir_nxt;
      dabort_r <= dabort_nxt;
      dunlock_r <= dunlock_nxt;
      idone_r <= idone_nxt;
      ifault_r <= ifault_nxt;
    end
  end

  assign data_done = ddone_r;
  assign data_done_fault = dfault_r;
  assign data_done_redir = dredir_r;
  assign data_done_abort_ack = dabort_r;
  assign data_done_unlock_ack = dunlock_r;
  assign instr_done = idone_r;
  assign instr_done_fault = ifault_r;

  // ==========================================================
  // read gathering; a redirected read fills the data side word
  srm_lane_capture #(.LANES(`SRM_LANES)) u_dcap (
    .clock(clock),
    .rst_n(rst_n),
    .capture_en(d_busy || redir_busy),
    .lane_en(redir_busy ? instr_in_lane_en : data_in_lane_en),
    .bus(redir_busy ? instr_rd_bus : data_rd_bus),
    .word(data_rd_word)
  );

  srm_lane_capture #(.LANES(`SRM_LANES)) u_icap (
    .clock(clock),
    .rst_n(rst_n),
    .capture_en(i_busy && !iredir_r),
    .lane_en(instr_in_lane_en),
    .bus(instr_rd_bus),
    .word(instr_rd_word)
  );

endmodule : srm_master

// ### testbench/srm_master_props.sv
// concurrent checks on the pins of the sram-style bus master
// assumes: bound into srm_master, names match its ports
module srm_master_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic data_req_ready,
  input wire logic data_rd_strobe,
  input wire logic data_wr_strobe,
  input wire logic data_sync_strobe,
  input wire logic [29:0] data_word_addr,
  input wire logic [3:0] data_out_lane_en,
  input wire logic [31:0] data_wr_bus,
  input wire logic data_wait,
  input wire logic data_redirect,
  input wire logic data_fault,
  input wire logic data_done,
  input wire logic data_done_fault,
  input wire logic instr_rd_strobe,
  input wire logic instr_wr_strobe,
  input wire logic instr_sync_strobe,
  input wire logic [29:0] instr_word_addr,
  input wire logic instr_wait
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ds;
  logic [2:0] is_;
  logic pend_r;
  logic ipend_r;
  assign ds = {data_sync_strobe, data_wr_strobe, data_rd_strobe};
  assign is_ = {instr_sync_strobe, instr_wr_strobe, instr_rd_strobe};
  // ======
  // a strobe seen last edge means a transaction is outstanding now
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      ipend_r <= 1'b0;
    end else begin
      pend_r <= |ds;
      ipend_r <= |is_;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_done;
    pend_r && !data_wait && !data_redirect;
  endsequence
  sequence s_redir;
    pend_r && !data_wait && data_redirect;
  endsequence
  AST_D_ONE: assert property ($onehot0(ds))
    else $error("data strobes overlap");
  AST_I_ONE: assert property ($onehot0(is_))
    else $error("instr strobes overlap");
  AST_HOLD: assert property (pend_r && data_wait |->
    $stable({ds, data_word_addr, data_out_lane_en, data_wr_bus})) else $error("moved in stall");
  AST_I_HOLD: assert property (ipend_r && instr_wait |->
    $stable({is_, instr_word_addr})) else $error("instr moved in stall");
  AST_NO_NEW: assert property (pend_r && data_wait |-> !data_req_ready)
    else $error("taken while stalled");
  AST_DONE: assert property (s_done |=> data_done)
    else $error("no done after completion");
  AST_CAUSE: assert property (data_done |->
    $past(pend_r && !data_wait) || $past(ipend_r && !instr_wait)) else $error("stray done");
  AST_STATUS: assert property (s_done |=> data_done_fault == $past(data_fault))
    else $error("fault not from completion");
  AST_REDIR: assert property (s_redir |=> is_ == $past(ds, 2)
    && instr_word_addr == $past(data_word_addr, 2)) else $error("redirect not reissued");
  AST_REDIR_BLOCK: assert property (s_redir |=> !(|ds) && !data_req_ready)
    else $error("data access during redirect");
  AST_RST_QUIET: assert property ($rose(rst_n) |-> ds == 3'h0 && is_ == 3'h0)
    else $error("strobe right after reset");
endmodule : srm_master_chk

bind srm_master srm_master_chk u_chk (.*);

// ### testbench/srm_agent.sv
// memory agent model for one side of the sram-style bus
// assumes: strobes settle before each rising edge of clock
module srm_agent (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] strb,
  input wire logic [29:0] addr,
  input wire logic [3:0] lanes,
  input wire logic [31:0] wdata,
  input wire logic [1:0] nwait,
  input wire logic [3:0] stat,
  input wire logic [3:0] rmask,
  output logic stall,
  output logic [31:0] rbus,
  output logic [3:0] rbe,
  output logic [3:0] flags
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [16];
  logic [31:0] rd_r;
  logic [3:0] st_r;
  logic [3:0] mk_r;
  logic [1:0] cnt_r;
  logic [1:0] left;
  logic busy_r;
  logic go;
  assign go = (strb != 3'h0) && !(busy_r && stall);
  assign left = go ? nwait : cnt_r - 2'h1;
  // ======
  // stall per waitstate, then answer with status
  // idle and stalled cycles show toggling junk so nothing stale looks valid
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      foreach (mem[i]) mem[i] <= 32'h0;
      busy_r <= 1'b0;
      stall <= 1'b0;
      rbus <= 32'h0;
      rbe <= 4'h0;
      st_r <= 4'h0;
      flags <= 4'h0;
    end else begin
      busy_r <= go || (busy_r && stall);
      cnt_r <= left;
      rbus <= ~rbus;
      rbe <= 4'h0;
      flags <= ~(go ? stat : st_r);
      stall <= ~stall;
      if (go) begin
        st_r <= stat;
        mk_r <= rmask & {4{strb[0]}};
        rd_r <= mem[addr[3:0]];
        // a redirected write belongs to the other side's memory, not this one
        for (int i = 0; i < 4; i++) begin
          if (strb[1] && lanes[i] && !stat[2]) begin
            mem[addr[3:0]][8*i+:8] <= wdata[8*i+:8];
          end
        end
      end
      if (go || (busy_r && stall)) begin
        stall <= left != 2'h0;
        if (left == 2'h0) begin
          rbus <= go ? mem[addr[3:0]] : rd_r;
          rbe <= go ? rmask & {4{strb[0]}} : mk_r;
          flags <= go ? stat : st_r;
        end
      end
    end
  end
endmodule : srm_agent

// ### testbench/test_sram_style_bus_master.sv
// self-checking bench for the sram-style bus master
// assumes: core files and agent compiled first
module test_sram_style_bus_master;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, data_req, data_req_ready, data_rd_strobe, data_wr_strobe, data_sync_strobe;
  logic data_done, data_done_fault, data_done_redir, data_done_abort_ack, data_done_unlock_ack;
  logic instr_req, instr_req_ready, instr_rd_strobe, instr_wr_strobe, instr_sync_strobe;
  logic instr_done, instr_done_fault;
  wire data_wait, data_fault, data_redirect, data_abort_ack, data_unlock_ack, instr_wait;
  wire instr_fault;
  wire [3:0] data_in_lane_en, instr_in_lane_en, iflags;
  wire [31:0] data_rd_bus, instr_rd_bus;
  srm_pkg::srm_kind_t data_req_kind;
  logic [29:0] data_req_addr, data_word_addr, instr_req_addr, instr_word_addr;
  logic [3:0] data_req_lanes, data_out_lane_en, instr_req_lanes, instr_out_lane_en;
  logic [3:0] dst, dmask, ist, imask;
  logic [31:0] data_req_wdata, data_wr_bus, data_rd_word, instr_rd_word, dword;
  logic [31:0] dmem [16];
  logic [31:0] imem [16];
  logic [1:0] dnw, inw;
  logic [35:0] dq [$];
  logic [32:0] iq [$];
  int errors, comparisons, i;
  int seed = 32'h1d720221;
  wire [5:0] strobes = {data_rd_strobe, data_wr_strobe, data_sync_strobe,
    instr_rd_strobe, instr_wr_strobe, instr_sync_strobe};
  assign instr_fault = iflags[3];
  always #5 clock = ~clock;
  srm_master u_dut (.*);
  srm_agent u_dag (.clock, .rst_n, .strb({data_sync_strobe, data_wr_strobe, data_rd_strobe}),
    .addr(data_word_addr), .lanes(data_out_lane_en), .wdata(data_wr_bus), .nwait(dnw),
    .stat(dst), .rmask(dmask), .stall(data_wait), .rbus(data_rd_bus), .rbe(data_in_lane_en),
    .flags({data_fault, data_redirect, data_abort_ack, data_unlock_ack}));
  srm_agent u_iag (.clock, .rst_n, .strb({instr_sync_strobe, instr_wr_strobe, instr_rd_strobe}),
    .addr(instr_word_addr), .lanes(instr_out_lane_en), .wdata(data_wr_bus), .nwait(inw),
    .stat(ist), .rmask(imask), .stall(instr_wait), .rbus(instr_rd_bus), .rbe(instr_in_lane_en),
    .flags(iflags));
  // ======
  // shared compare, lane merge, verdict
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] m);
    for (int k = 0; k < 4; k++) if (m[k]) o[8*k+:8] = n[8*k+:8];
    return o;
  endfunction : merge
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // waits are bounded: a lost handshake ends the run as a failure
  task automatic stuck();
    errors++;
    $display("[ERR] %0t handshake timed out", $time);
    results();
  endtask : stuck
  task automatic take(input bit ins);
    int n;
    #1;
    for (n = 0; n < 40 && (ins ? instr_req_ready : data_req_ready) !== 1'b1; n++) begin
      @(negedge clock);
      #1;
    end
    if (n == 40) stuck();
    @(posedge clock);
    if (ins) instr_req <= 1'b0;
    else data_req <= 1'b0;
    @(negedge clock);
  endtask : take
  task automatic drain();
    int n;
    for (n = 0; n < 60 && dq.size() + iq.size() > 0; n++) @(negedge clock);
    if (n == 60) stuck();
  endtask : drain
  // ======
  // drivers note the expected result at launch
  task automatic dacc(input int k, a, input logic [3:0] l, input int nw, input logic [3:0] st, m);
    logic [31:0] w;
    w = $random(seed);
    data_req = 1'b1;
    data_req_kind = srm_pkg::srm_kind_t'(k);
    data_req_addr = 30'(a);
    data_req_lanes = l;
    data_req_wdata = w;
    dnw = 2'(nw);
    dst = st;
    dmask = m;
    if (k == 1 && st[2]) imem[a] = merge(imem[a], w, l);
    else if (k == 1) dmem[a] = merge(dmem[a], w, l);
    else if (k == 0) dword = merge(dword, st[2] ? imem[a] : dmem[a], st[2] ? imask : m);
    dq.push_back({dword, st[2] ? {ist[3], 3'h4} : st});
    take(1'b0);
  endtask : dacc
  task automatic ifetch(input int a, nw);
    instr_req = 1'b1;
    instr_req_addr = 30'(a);
    instr_req_lanes = 4'hF;
    inw = 2'(nw);
    iq.push_back({imem[a], ist[3]});
    take(1'b1);
  endtask : ifetch
  task automatic do_reset();
    rst_n = 1'b0;
    data_req = 1'b1;
    instr_req = 1'b1;
    dword = 32'h0;
    foreach (dmem[j]) dmem[j] = 32'h0;
    foreach (imem[j]) imem[j] = 32'h0;
    repeat (5) @(negedge clock);
    check(36'(strobes), 36'h0);
    rst_n = 1'b1;
    #1;
    check(36'(strobes), 36'h0);
    check(36'(data_rd_word), 36'h0);
    @(negedge clock);
    data_req = 1'b0;
    instr_req = 1'b0;
    // one idle cycle, so the next request is not raised in the same step
    @(negedge clock);
  endtask : do_reset
  // results come back in launch order
  always @(negedge clock) begin
    if (data_done === 1'b1) begin
      if (dq.size() == 0) check(36'h0, 36'h1);
      else check({data_rd_word, data_done_fault, data_done_redir, data_done_abort_ack,
        data_done_unlock_ack}, dq.pop_front());
    end
    if (instr_done === 1'b1) begin
      if (iq.size() == 0) check(36'h0, 36'h1);
      else check({3'h0, instr_rd_word, instr_done_fault}, {3'h0, iq.pop_front()});
    end
  end
  initial begin
    #100000;
    stuck();
  end
  initial begin
    clock = 1'b0;
    errors = 0;
    comparisons = 0;
    data_req_kind = srm_pkg::SRM_K_READ;
    {data_req_addr, data_req_lanes, data_req_wdata, instr_req_addr, instr_req_lanes} = '0;
    {dnw, dst, dmask, inw, ist, imask} = '0;
    do_reset();
    // writes, reads, syncs back to back with 0..2 waitstates and status mixes
    for (i = 0; i < 15; i++) dacc(i < 6 ? 1 : i < 12 ? 0 : 2, i % 6, 4'($random(seed)), i % 3,
      4'(i & 11), 4'($random(seed)));
    drain();
    // redirected write then redirected read with a fault on the instruction side
    inw = 2'h1;
    imask = 4'hF;
    dacc(1, 9, 4'hF, 1, 4'h4, 4'h0);
    drain();
    ist = 4'h8;
    imask = 4'h6;
    dacc(0, 9, 4'h0, 0, 4'h4, 4'h0);
    dacc(0, 1, 4'hF, 0, 4'h0, 4'hF);
    drain();
    ist = 4'h0;
    imask = 4'hF;
    for (i = 0; i < 3; i++) ifetch(9 - i, i);
    drain();
    // second reset in mid-run, then traffic again
    do_reset();
    dacc(1, 2, 4'hF, 0, 4'h0, 4'h0);
    dacc(0, 2, 4'hF, 1, 4'h0, 4'hF);
    drain();
    results();
  end
endmodule : test_sram_style_bus_master
